// file: asr_consts.svh
// Shared constants for the converter readout block
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define ASR_CONV_TIME_US  16600
`define ASR_MCLK_MHZ      250
`define ASR_CONV_CYCLES   (`ASR_CONV_TIME_US * `ASR_MCLK_MHZ)

// -----------------------------------------------------------------
// Result and serial framing
// -----------------------------------------------------------------
`define ASR_RES_W         16
`define ASR_RES_MSB       15
`define ASR_CNT_W         23
`define ASR_BIT_W         4
`define ASR_BIT_FIRST     4'h0
`define ASR_BIT_LAST      4'hf
`define ASR_BIT_STEP      4'h1
`define ASR_SYNC_W        2
`define ASR_SYNC_SEL      0
`define ASR_SYNC_SCK      1
`define ASR_RES_RST       16'h0000
`define ASR_CNT_RST       23'h00_0000

`endif

// file: asr_host_model.sv
// Host serial controller model reading converter results
`timescale 1ns/1ps
module asr_host_model (
  input  wire logic mclk,
  input  wire logic data_in,
  output logic      select_n,
  output logic      shift_clock_in
);
  // ---------------------------------------------------------------
  // Pin drive, changed on mclk falls, idle with both pins high
  // ---------------------------------------------------------------
  initial begin
    select_n       = 1'b1;
    shift_clock_in = 1'b1;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle
  task automatic sel(input logic v);
    @(negedge mclk);
    select_n = v;
  endtask : sel
  // Halves of 10 mclk give the 80 ns link clock
  task automatic toggle(input int n);
    repeat (n) begin
      idle(10);
      shift_clock_in = 1'b0;
      idle(10);
      shift_clock_in = 1'b1;
    end
  endtask : toggle
  // Short frames end by select rise, so the rest is lost
  task automatic frame(input int nbits, output logic [15:0] word);
    word = 16'h0000;
    sel(1'b0);
    idle(30);
    shift_clock_in = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      idle(10);
      shift_clock_in = 1'b1;
      word = {word[14:0], data_in};
      idle(10);
      shift_clock_in = 1'b0;
    end
    idle(10);
    select_n       = 1'b1;
    shift_clock_in = 1'b1;
  endtask : frame
endmodule : asr_host_model

// file: asr_pkg.sv
// Types for the converter readout block
package asr_pkg;

  // -----------------------------------------------------------------
  // Sequencer states, Gray along convert, hold, readout
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASR_CONVERT = 2'h0,
    ASR_HOLD    = 2'h1,
    ASR_READOUT = 2'h3
  } asr_state_t;

endpackage : asr_pkg

// file: asr_readout.sv
// Conversion sequencer and serial result readout
`timescale 1ns/1ps
`include "asr_consts.svh"

module asr_readout #(
  parameter int CONV_CYCLES = `ASR_CONV_CYCLES
) (
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic                  select_n,
  input  wire logic                  shift_clock_in,
  input  wire logic [`ASR_RES_W-1:0] sample_in,
  output logic                       serial_out_pin,
  output logic                       serial_out_oe,
  output logic                       result_ready
);

  // -----------------------------------------------------------------
  // Pin synchronisation and edges
  // -----------------------------------------------------------------
  logic [`ASR_SYNC_W-1:0] pins_s;
  logic                   sel_s;
  logic                   sck_s;
  logic                   sel_d;
  logic                   sck_d;
  logic                   sck_fall;
  logic                   sel_rise;

  asr_sync u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in ({shift_clock_in, select_n}),
    .sync_out (pins_s)
  );

  assign sel_s    = pins_s[`ASR_SYNC_SEL];
  assign sck_s    = pins_s[`ASR_SYNC_SCK];
  assign sck_fall = sck_d & ~sck_s;
  assign sel_rise = sel_s & ~sel_d;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sel_d <= 1'b1;
      sck_d <= 1'b1;
    end else begin
      sel_d <= sel_s;
      sck_d <= sck_s;
    end
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  localparam logic [`ASR_CNT_W-1:0] CONV_LAST = `ASR_CNT_W'(CONV_CYCLES - 1);

  asr_pkg::asr_state_t            state;
  asr_pkg::asr_state_t            next_state;
  logic [`ASR_CNT_W-1:0]          conv_cnt;
  logic [`ASR_RES_W-1:0]          result;
  logic [`ASR_RES_W-1:0]          shreg;
  logic [`ASR_RES_W-2:0]          shreg_low;
  logic [`ASR_BIT_W-1:0]          bit_cnt;
  logic                           conv_done;
  logic                           start_read;

  assign conv_done  = (conv_cnt == CONV_LAST);
  assign start_read = !sel_s && !sck_s;
  assign shreg_low  = shreg[`ASR_RES_MSB-1:0];

  always_comb begin
    next_state = state;
    case (state)
      asr_pkg::ASR_CONVERT: begin
        // Only reset stops a running conversion
        if (conv_done) begin
          next_state = asr_pkg::ASR_HOLD;
        end
      end
      asr_pkg::ASR_HOLD: begin
        if (start_read) begin
          next_state = asr_pkg::ASR_READOUT;
        end
      end
      asr_pkg::ASR_READOUT: begin
        if (sel_rise || (sck_fall && bit_cnt == `ASR_BIT_LAST)) begin
          next_state = asr_pkg::ASR_CONVERT;
        end
      end
      default: begin
        next_state = asr_pkg::ASR_CONVERT;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state <= asr_pkg::ASR_CONVERT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      conv_cnt <= `ASR_CNT_RST;
    end else if (state == asr_pkg::ASR_CONVERT && !conv_done) begin
      conv_cnt <= conv_cnt + `ASR_CNT_W'(1);
    end else begin
      conv_cnt <= `ASR_CNT_RST;
    end
  end

  // Result stays static through hold, however long the host waits
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      result <= `ASR_RES_RST;
    end else if (state == asr_pkg::ASR_CONVERT && conv_done) begin
      result <= sample_in;
    end
  end

  // -----------------------------------------------------------------
  // Shift register
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      shreg   <= `ASR_RES_RST;
      bit_cnt <= `ASR_BIT_FIRST;
    end else if (state == asr_pkg::ASR_HOLD && start_read) begin
      shreg   <= result;
      bit_cnt <= `ASR_BIT_FIRST;
    end else if (state == asr_pkg::ASR_READOUT && sck_fall) begin
      shreg   <= {shreg_low, 1'b0};
      bit_cnt <= bit_cnt + `ASR_BIT_STEP;
    end
  end

  // -----------------------------------------------------------------
  // Data pin
  // -----------------------------------------------------------------
  // Busy reads high, done-and-holding reads low
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      serial_out_pin <= 1'b1;
    end else begin
      case (state)
        asr_pkg::ASR_READOUT: serial_out_pin <= shreg[`ASR_RES_MSB];
        asr_pkg::ASR_HOLD:    serial_out_pin <= 1'b0;
        default:              serial_out_pin <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= !sel_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      result_ready <= 1'b0;
    end else begin
      result_ready <= (next_state != asr_pkg::ASR_CONVERT);
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_OE_DRIVE: assert property (!sel_s |=> serial_out_oe)
    else $error("data pin not driven while selected");
  AST_OE_RELEASE: assert property (sel_s |=> !serial_out_oe)
    else $error("data pin driven while deselected");
  AST_BUSY: assert property (state == asr_pkg::ASR_CONVERT |=> serial_out_pin)
    else $error("busy status missing during conversion");
  AST_NO_SHIFT_CONV: assert property ((state == asr_pkg::ASR_CONVERT) |=> $stable(shreg))
    else $error("shift register moved during conversion");
  AST_HOLD_SEL: assert property ((state == asr_pkg::ASR_HOLD && sel_s) |=> state == asr_pkg::ASR_HOLD)
    else $error("left hold while deselected");
  AST_ENTER_READ: assert property ((state == asr_pkg::ASR_HOLD && start_read)
                                   |=> state == asr_pkg::ASR_READOUT)
    else $error("readout not entered");
  AST_MSB_FIRST: assert property ((state == asr_pkg::ASR_HOLD && start_read)
                                  |=> ##1 serial_out_pin == result[`ASR_RES_MSB])
    else $error("first bit is not the msb");
  AST_SHIFT: assert property ((state == asr_pkg::ASR_READOUT && sck_fall)
                              |=> shreg[`ASR_RES_MSB:1] == $past(shreg_low))
    else $error("no shift on clock fall");
  AST_END16: assert property ((state == asr_pkg::ASR_READOUT && sck_fall && bit_cnt == `ASR_BIT_LAST)
                              |=> state == asr_pkg::ASR_CONVERT)
    else $error("readout did not end at sixteenth fall");
  AST_ABORT: assert property ((state == asr_pkg::ASR_READOUT && sel_rise)
                              |=> state == asr_pkg::ASR_CONVERT)
    else $error("select rise did not abort readout");
  AST_CONV_TIME: assert property ((state == asr_pkg::ASR_HOLD && $past(state) == asr_pkg::ASR_CONVERT)
                                  |-> $past(conv_cnt) == CONV_LAST)
    else $error("conversion length wrong");

  COV_READ: cover property (state == asr_pkg::ASR_HOLD ##1 state == asr_pkg::ASR_READOUT);
  COV_FULL: cover property (state == asr_pkg::ASR_READOUT && sck_fall && bit_cnt == `ASR_BIT_LAST);
  COV_ABORT: cover property (state == asr_pkg::ASR_READOUT && sel_rise);

endmodule : asr_readout

// file: asr_readout_tb.sv
// Self-checking bench for the converter readout block
`timescale 1ns/1ps
module asr_readout_tb;
  // ---------------------------------------------------------------
  // Bench
  // ---------------------------------------------------------------
  localparam int CONV = 200;
  logic        mclk;
  logic        nrst;
  logic [15:0] sample_in;
  logic [15:0] w;
  logic        select_n;
  logic        shift_clock_in;
  logic        serial_out_pin;
  logic        serial_out_oe;
  logic        result_ready;
  wire         data_line;
  int          failures;
  int          checks_done;
  assign data_line = serial_out_oe ? serial_out_pin : 1'bz;
  asr_readout #(.CONV_CYCLES(CONV)) dut (
    .mclk(mclk), .nrst(nrst), .select_n(select_n), .shift_clock_in(shift_clock_in),
    .sample_in(sample_in), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .result_ready(result_ready));
  asr_host_model host (
    .mclk(mclk), .data_in(data_line), .select_n(select_n), .shift_clock_in(shift_clock_in));
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  function automatic logic [15:0] b16(input logic v);
    return {15'h0000, v};
  endfunction : b16
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Bounded wait, also shows the conversion is not cut short
  // Lower bound depends on how far the conversion ran before the wait began
  task automatic wait_ready(input int min_n);
    int n;
    n = 0;
    while (result_ready !== 1'b1 && n < CONV + 50) begin
      @(negedge mclk);
      n++;
    end
    check(b16(result_ready), 16'h0001);
    check(b16(n > min_n), 16'h0001);
  endtask : wait_ready
  task automatic t_status;
    host.sel(1'b0);
    host.idle(6);
    check(b16(data_line), 16'h0001);
    check(b16(result_ready), 16'h0000);
    wait_ready(CONV - 20);
    host.idle(5);
    check(b16(data_line), 16'h0000);
    host.sel(1'b1);
    host.idle(5);
    check(b16(data_line), b16(1'bz));
    host.frame(16, w);
    check(w, 16'ha5c3);
    check(b16(result_ready), 16'h0000);
    host.sel(1'b0);
    host.idle(5);
    check(b16(data_line), 16'h0001);
    host.sel(1'b1);
  endtask : t_status
  // Word derived from the last one: byte swap and invert gives 3c5a
  task automatic t_ignore;
    sample_in = ~{sample_in[7:0], sample_in[15:8]};
    host.sel(1'b0);
    host.toggle(4);
    check(b16(data_line), 16'h0001);
    host.sel(1'b1);
    wait_ready(CONV / 4);
    host.frame(16, w);
    check(w, 16'h3c5a);
  endtask : t_ignore
  task automatic t_hold;
    sample_in = {~sample_in[15], 14'h0000, ~sample_in[0]};
    wait_ready(CONV - 20);
    host.toggle(3);
    check(b16(result_ready), 16'h0001);
    host.sel(1'b0);
    host.idle(5);
    check(b16(data_line), 16'h0000);
    host.sel(1'b1);
    host.frame(16, w);
    check(w, 16'h8001);
  endtask : t_hold
  task automatic t_abort;
    sample_in = sample_in ^ 16'h42a4;
    wait_ready(CONV - 20);
    host.frame(5, w);
    check(w, 16'h0018);
    host.idle(8);
    check(b16(result_ready), 16'h0000);
    sample_in = sample_in ^ 16'hbd5b;
    wait_ready(CONV - 20);
    host.frame(16, w);
    check(w, 16'h7ffe);
  endtask : t_abort
  initial begin
    nrst      = 1'b0;
    sample_in = 16'ha5c3;
    failures  = 0;
    checks_done = 0;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    t_status();
    t_ignore();
    t_hold();
    t_abort();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("unexpected at %0t: run did not finish", $time);
    end_sim();
  end
endmodule : asr_readout_tb

// file: asr_sync.sv
// Two-flop synchronisers for the pin inputs
`timescale 1ns/1ps
`include "asr_consts.svh"

module asr_sync (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic [`ASR_SYNC_W-1:0] async_in,
  output logic      [`ASR_SYNC_W-1:0] sync_out
);

  // -----------------------------------------------------------------
  // Synchroniser chains
  // -----------------------------------------------------------------
  // Resets high so an idle select reads as deselected
  logic [`ASR_SYNC_W-1:0] meta;

  for (genvar i = 0; i < `ASR_SYNC_W; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        meta[i]     <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta[i]     <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  end

endmodule : asr_sync
